// [core/dio_pkg.sv]
// shared constants of the digital i/o, totalizer and alarm unit
package dio_pkg;
	// register bus shape
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register byte offsets
	localparam logic [7:0] OFF_INPUT_WORD_QUERY = 8'h00;
	localparam logic [7:0] OFF_OUT_CMD = 8'h04;
	localparam logic [7:0] OFF_TOTAL = 8'h08;
	localparam logic [7:0] OFF_TOTAL_ZERO = 8'h0c;
	localparam logic [7:0] OFF_CTRL = 8'h10;
	localparam logic [7:0] OFF_INTERVAL = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_LIMIT0 = 8'h20;
	localparam logic [7:0] LIMIT_STRIDE = 8'h04;
	// field positions
	localparam int OUT_NUM_W = 8;
	localparam int OUT_LEVEL_BIT = 8;
	localparam int TOTAL_W = 16;
	localparam int TOTAL_OL_BIT = 16;
	localparam int ZERO_BIT = 0;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_EXT_SCAN_ENABLE_SETTING_BIT = 1;
	localparam int CTRL_TOTAL_MODE_BIT = 2;
	localparam int STATUS_RUN_BIT = 16;
	// channel counts
	localparam int N_DIN = 8;
	localparam int N_DOUT = 8;
	localparam int N_ALARM = 4;
	localparam int SYNC_W = N_DIN + 2;
	localparam int TOT_SYNC_BIT = N_DIN;
	localparam int EXT_SYNC_BIT = N_DIN + 1;
	// reset values
	localparam logic [7:0] DOUT_RST = 8'hff;
	localparam logic [3:0] ALARM_RST = 4'hf;
	localparam logic [15:0] TOTAL_RST = 16'h0000;
	localparam logic [15:0] TOTAL_FULL = 16'hffff;
	localparam logic [15:0] INTERVAL_RST = 16'h0001;
	localparam logic [31:0] LIMIT_RST = 32'h7fffffff;
	// timing: one interval unit is one second
	localparam longint CLK_FREQ_HZ = 20000000;
	localparam longint TICK_PERIOD_MS = 1000;
	localparam int unsigned TICK_CYCLES = 32'(TICK_PERIOD_MS * CLK_FREQ_HZ / 64'd1000);
endpackage : dio_pkg

// [core/sync_edge.sv]
// two-flop pin synchroniser with per-bit edge pulses
`timescale 1ns/1ns
module sync_edge (
	input wire logic ref_clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic [dio_pkg::SYNC_W-1:0] pinIn, // raw pins, idle high
	output logic [dio_pkg::SYNC_W-1:0] level, // synchronised level
	output logic [dio_pkg::SYNC_W-1:0] rise, // one-cycle low-to-high pulse
	output logic [dio_pkg::SYNC_W-1:0] fall // one-cycle high-to-low pulse
);
	import dio_pkg::*;

	// three stages: two to settle, one to compare against
	typedef struct packed {
		logic [SYNC_W-1:0] s1; // first flop, read only by s2
		logic [SYNC_W-1:0] s2; // settled level
		logic [SYNC_W-1:0] s3; // previous settled level
	} syn_type;

	syn_type st_ff;
	syn_type nxt_st;

	// shift chain
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = pinIn;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
	end

	// pins rest pulled up, so reset to ones avoids a false edge
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// edges per bit; each transition gives one pulse only
	for (genvar i = 0; i < SYNC_W; i++) begin : g_edge
		assign level[i] = st_ff.s2[i];
		assign rise[i] = st_ff.s2[i] & ~st_ff.s3[i]; // R19
		assign fall[i] = ~st_ff.s2[i] & st_ff.s3[i]; // R19
	end
endmodule : sync_edge

// [core/interval_timer.sv]
// scan interval timer counting whole seconds
`timescale 1ns/1ns
module interval_timer #(
	parameter int unsigned TICK_CYCLES = dio_pkg::TICK_CYCLES // clocks per second
) (
	input wire logic ref_clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic run, // scanning switched on
	input wire logic [15:0] interval, // seconds between scans
	output logic tick // one-cycle scan request
);
	import dio_pkg::*;

	typedef struct packed {
		logic [31:0] div; // cycles inside the current second
		logic [15:0] sec; // seconds inside the current interval
		logic runDly; // run one cycle ago
		logic tick; // registered request
	} tmr_type;

	tmr_type st_ff;
	tmr_type nxt_st;

	// a scan at start, then one per interval; zero acts as one
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		nxt_st.runDly = run;
		if (!run) begin
			// idle: hold counters cleared
			nxt_st.div = '0;
			nxt_st.sec = '0;
		end else if (!st_ff.runDly) begin
			// start of scanning
			nxt_st.tick = 1'b1; // R15
			nxt_st.div = '0;
			nxt_st.sec = '0;
		end else if (st_ff.div == 32'(TICK_CYCLES - 1)) begin
			nxt_st.div = '0;
			if (17'(st_ff.sec) + 17'h00001 >= 17'(interval)) begin
				nxt_st.sec = '0;
				nxt_st.tick = 1'b1; // R15
			end else begin
				nxt_st.sec = st_ff.sec + 16'h0001;
			end
		end else begin
			nxt_st.div = st_ff.div + 32'h00000001;
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;
endmodule : interval_timer

// [core/digital_io_totalizer_alarm_unit.sv]
// digital i/o, totalizer and alarm unit top level
`timescale 1ns/1ns
// What this block does
// [R1] input word query returns eight input bits
// [R2] grounded input reads zero in its bit
// [R3] level 0 drives output low, 1 high
// [R4] all outputs high after reset
// [R5] totalizer count zero after reset
// [R6] one count per complete low-high pulse
// [R7] successive pulses accumulate
// [R8] count holds to 65535, loadable by host
// [R9] pulse at full range raises overload
// [R10] zero request in total mode clears count
// [R11] periodic input advances one per cycle
// [R12] four alarm outputs high after reset
// [R13] alarm off while reading not above limit
// [R14] reading above limit drives alarm low
// [R15] scan repeats every programmed interval
// [R16] external scan pin ignored unless enabled
// [R17] pin closure gives exactly one extra scan; a closure on an interval tick cycle adds none
// [R18] pin release leaves interval scanning undisturbed
// [R19] pins synchronised, edges counted once
// [R20] overload holds until zero or load
// [R21] output number above 7 changes nothing
module digital_io_totalizer_alarm_unit #(
	parameter int unsigned TICK_CYCLES = dio_pkg::TICK_CYCLES // clocks per second
) (
	input wire logic ref_clk, // system clock, 20 MHz
	input wire logic rstn, // async reset, active low
	input wire logic [dio_pkg::ADDR_W-1:0] regAddr, // register byte address
	input wire logic [dio_pkg::DATA_W-1:0] regWdata, // write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic [dio_pkg::DATA_W-1:0] regRdata, // read data, cycle after strobe
	input wire logic [dio_pkg::N_DIN-1:0] digInPin, // digital inputs, low when grounded
	input wire logic totalPin, // totalizer pulse input
	input wire logic externalScanPinN, // external scan pin, low when shorted
	output logic [dio_pkg::N_DOUT-1:0] digOutN, // digital outputs, low is on
	output logic [dio_pkg::N_ALARM-1:0] alarmOutN, // alarm outputs, low is on
	output logic scanStart, // one-cycle request for one scan
	input wire logic resultValid, // scan engine reading strobe
	input wire logic [4:0] resultChan, // channel of the reading
	input wire logic signed [31:0] resultValue // reading, signed counts
);
	import dio_pkg::*;

	// whole block state
	typedef struct packed {
		logic [N_DOUT-1:0] digOut; // output levels, 1 is off
		logic [N_ALARM-1:0] alarm; // alarm levels, 1 is off
		logic [TOTAL_W-1:0] count; // totalizer count
		logic overloadIndication; // counter overrun
		logic scanRun; // scanning on
		logic extScanEnableSetting; // external pin honoured
		logic totalMode; // totalizer display mode
		logic [15:0] interval; // seconds per scan
		logic [N_ALARM-1:0][31:0] limit; // high alarm limits
		logic scanStart; // registered scan request
		logic [15:0] scanCount; // scans requested so far
		logic [DATA_W-1:0] rdata; // read answer
	} dio_type;

	dio_type st_ff; // state register
	dio_type nxt_st; // next state

	logic [SYNC_W-1:0] syncLvl; // synchronised pin levels
	logic [SYNC_W-1:0] syncRise; // rising edge pulses
	logic [SYNC_W-1:0] syncFall; // falling edge pulses
	logic intervalTick; // interval scan request
	logic totRise; // completed totalizer pulse
	logic extClose; // external pin closure
	logic loadHit; // host load of the count
	logic zeroHit; // host zero request
	logic chanHit; // reading of an alarm channel
	logic overLimit; // reading above its limit

	// all pins pass two flops before any logic reads them
	sync_edge u_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.pinIn({externalScanPinN, totalPin, digInPin}),
		.level(syncLvl),
		.rise(syncRise),
		.fall(syncFall)
	);

	// interval scanning; the pin never touches this timer
	interval_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(st_ff.scanRun),
		.interval(st_ff.interval),
		.tick(intervalTick)
	);

	// a pulse is complete on its return to high
	assign totRise = syncRise[TOT_SYNC_BIT]; // R6
	// closure is the high-to-low edge, so a held short fires once
	assign extClose = syncFall[EXT_SYNC_BIT]; // R19
	assign loadHit = regWr && (regAddr == OFF_TOTAL); // R8
	// zero only acts while the totalizer is the shown mode
	assign zeroHit = regWr && (regAddr == OFF_TOTAL_ZERO) && regWdata[ZERO_BIT] && st_ff.totalMode; // R10
	assign chanHit = resultValid && st_ff.scanRun && (resultChan < 5'(N_ALARM));
	assign overLimit = resultValue > $signed(st_ff.limit[resultChan[1:0]]); // R14

	// next state: writes, counter, alarms, scan requests, reads
	always_comb begin
		nxt_st = st_ff;
		nxt_st.scanStart = 1'b0;
		nxt_st.rdata = '0;

		// plain register writes
		if (regWr) begin
			case (regAddr)
				OFF_OUT_CMD: begin
					// numbers 8 and up fall through unchanged
					if (regWdata[OUT_NUM_W-1:0] < 8'(N_DOUT)) begin // R21
						nxt_st.digOut[regWdata[2:0]] = regWdata[OUT_LEVEL_BIT]; // R3
					end
				end
				OFF_CTRL: begin
					nxt_st.scanRun = regWdata[CTRL_RUN_BIT];
					nxt_st.extScanEnableSetting = regWdata[CTRL_EXT_SCAN_ENABLE_SETTING_BIT];
					nxt_st.totalMode = regWdata[CTRL_TOTAL_MODE_BIT];
				end
				OFF_INTERVAL: begin
					nxt_st.interval = regWdata[15:0];
				end
				default: begin
					// other offsets carry no plain storage
				end
			endcase
			// one high limit per alarm channel
			for (int i = 0; i < N_ALARM; i++) begin
				if (regAddr == OFF_LIMIT0 + 8'(i) * LIMIT_STRIDE) begin
					nxt_st.limit[i] = regWdata;
				end
			end
		end

		// host load or zero first, then the pulse, so a pulse in
		// the same cycle as a clear is still counted
		if (loadHit) begin
			nxt_st.count = regWdata[TOTAL_W-1:0]; // R8
			nxt_st.overloadIndication = 1'b0; // R20
		end else if (zeroHit) begin
			nxt_st.count = TOTAL_RST; // R10
			nxt_st.overloadIndication = 1'b0; // R20
		end
		if (totRise && !nxt_st.overloadIndication) begin
			if (nxt_st.count == TOTAL_FULL) begin
				// no silent wrap: count stays, overrun flagged
				nxt_st.overloadIndication = 1'b1; // R9
			end else begin
				nxt_st.count = nxt_st.count + 16'h0001; // R7 R11
			end
		end

		// alarm follows each scanned reading of channels 0 to 3
		if (chanHit) begin
			nxt_st.alarm[resultChan[1:0]] = !overLimit; // R13 R14
		end

		// interval scans plus one extra scan per enabled closure not on an interval tick cycle
		if (intervalTick) begin
			nxt_st.scanStart = 1'b1; // R15 R18
		end
		if (extClose && st_ff.extScanEnableSetting && st_ff.scanRun) begin // R16
			nxt_st.scanStart = 1'b1; // R17
		end
		if (nxt_st.scanStart) begin
			nxt_st.scanCount = st_ff.scanCount + 16'h0001;
		end

		// read answers; unmapped offsets read zero
		if (regRd) begin
			case (regAddr)
				OFF_INPUT_WORD_QUERY: begin
					// bit n is input n, grounded reads zero
					nxt_st.rdata = {24'h000000, syncLvl[N_DIN-1:0]}; // R1 R2
				end
				OFF_OUT_CMD: begin
					nxt_st.rdata = {24'h000000, st_ff.digOut};
				end
				OFF_TOTAL: begin
					nxt_st.rdata = {15'h0000, st_ff.overloadIndication, st_ff.count};
				end
				OFF_CTRL: begin
					nxt_st.rdata = {29'h00000000, st_ff.totalMode, st_ff.extScanEnableSetting, st_ff.scanRun};
				end
				OFF_INTERVAL: begin
					nxt_st.rdata = {16'h0000, st_ff.interval};
				end
				OFF_STATUS: begin
					nxt_st.rdata = {15'h0000, st_ff.scanRun, st_ff.scanCount};
				end
				default: begin
					nxt_st.rdata = '0;
				end
			endcase
			for (int i = 0; i < N_ALARM; i++) begin
				if (regAddr == OFF_LIMIT0 + 8'(i) * LIMIT_STRIDE) begin
					nxt_st.rdata = st_ff.limit[i];
				end
			end
		end
	end

	// state register; reset leaves every digital and alarm output off and high
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
			st_ff.digOut <= DOUT_RST; // R4
			st_ff.alarm <= ALARM_RST; // R12
			st_ff.count <= TOTAL_RST; // R5
			st_ff.interval <= INTERVAL_RST;
			st_ff.limit <= {N_ALARM{LIMIT_RST}};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from flops
	assign digOutN = st_ff.digOut;
	assign alarmOutN = st_ff.alarm;
	assign scanStart = st_ff.scanStart;
	assign regRdata = st_ff.rdata;

	// helper for checking only: has any output command been given
	logic outTouched_ff;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			outTouched_ff <= 1'b0;
		end else if (regWr && regAddr == OFF_OUT_CMD) begin
			outTouched_ff <= 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// named steps of host access and pin events
	sequence s_word_query;
		regRd && regAddr == OFF_INPUT_WORD_QUERY;
	endsequence
	sequence s_out_cmd;
		regWr && regAddr == OFF_OUT_CMD && regWdata[OUT_NUM_W-1:0] < 8'(N_DOUT);
	endsequence
	sequence s_plain_pulse;
		totRise && !loadHit && !zeroHit;
	endsequence

	property p_word_query;
		s_word_query |=> regRdata == {24'h000000, $past(syncLvl[N_DIN-1:0])};
	endproperty
	a_word_query: assert property (p_word_query) else $error("input word answer wrong"); // R1

	property p_grounded_bit;
		s_word_query ##0 !syncLvl[0] |=> !regRdata[0] && regRdata[31:8] == 24'h000000;
	endproperty
	a_grounded_bit: assert property (p_grounded_bit) else $error("grounded input not zero"); // R2

	property p_out_cmd;
		logic [2:0] n;
		logic v;
		(s_out_cmd, n = regWdata[2:0], v = regWdata[OUT_LEVEL_BIT]) |=> digOutN[n] == v;
	endproperty
	a_out_cmd: assert property (p_out_cmd) else $error("output level not applied"); // R3

	property p_out_rest;
		!outTouched_ff |-> digOutN == DOUT_RST;
	endproperty
	a_out_rest: assert property (p_out_rest) else $error("output left off state"); // R4

	property p_bad_num;
		regWr && regAddr == OFF_OUT_CMD && regWdata[OUT_NUM_W-1:0] >= 8'(N_DOUT) |=> $stable(digOutN);
	endproperty
	a_bad_num: assert property (p_bad_num) else $error("bad output number changed outputs"); // R21

	property p_count_up;
		s_plain_pulse ##0 !st_ff.overloadIndication ##0 st_ff.count != TOTAL_FULL
			|=> st_ff.count == $past(st_ff.count) + 16'h0001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("pulse not counted once"); // R6

	property p_overrun;
		s_plain_pulse ##0 st_ff.count == TOTAL_FULL |=> st_ff.overloadIndication && st_ff.count == TOTAL_FULL;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // R9

	property p_ol_hold;
		st_ff.overloadIndication && !loadHit && !zeroHit |=> st_ff.overloadIndication && $stable(st_ff.count);
	endproperty
	a_ol_hold: assert property (p_ol_hold) else $error("overload not held"); // R20

	property p_zero;
		zeroHit && !totRise |=> st_ff.count == TOTAL_RST && !st_ff.overloadIndication;
	endproperty
	a_zero: assert property (p_zero) else $error("zero request ignored"); // R10

	property p_alarm;
		logic [1:0] c;
		logic on;
		(chanHit, c = resultChan[1:0], on = overLimit) |=> alarmOutN[c] == !on;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm does not follow limit"); // R14

	property p_pin_off;
		extClose && !st_ff.extScanEnableSetting && !intervalTick |=> !scanStart;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("disabled pin started scan"); // R16

	property p_pin_scan;
		// an interval tick right behind the closure may stretch the pulse by one cycle
		extClose && st_ff.extScanEnableSetting && st_ff.scanRun |=> scanStart ##1 (!scanStart || $past(intervalTick));
	endproperty
	a_pin_scan: assert property (p_pin_scan) else $error("closure scan missing"); // R17

	property p_first_scan;
		$rose(st_ff.scanRun) |-> ##2 scanStart;
	endproperty
	a_first_scan: assert property (p_first_scan) else $error("scan not started"); // R15
endmodule : digital_io_totalizer_alarm_unit

// [tb/scan_engine_model.sv]
// scan engine model answering scan requests with channel readings
`timescale 1ns/1ns
module scan_engine_model #(
	parameter int LATENCY = 3 // cycles from request to scan start; first reading one cycle later
) (
	input wire logic ref_clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic scanStart, // one-scan request
	input wire logic signed [31:0] level, // reading given to every channel
	output logic resultValid, // reading strobe
	output logic [4:0] resultChan, // channel of the reading
	output logic signed [31:0] resultValue // reading
);
	int waitCnt; // cycles left before the scan begins
	int chanCnt; // next channel to report, 5 means idle
	// a scan reports channels 0 to 4; channel 4 owns no alarm output
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			waitCnt <= 0;
			chanCnt <= 5;
			resultValid <= 1'b0;
			resultChan <= 5'h1f;
			resultValue <= 32'h0;
		end else begin
			// idle lines toggle so a stale reading is never mistaken for data
			resultValid <= 1'b0;
			resultChan <= ~resultChan;
			resultValue <= ~resultValue;
			if (scanStart) begin
				waitCnt <= LATENCY;
			end else if (waitCnt > 1) begin
				waitCnt <= waitCnt - 1;
			end else if (waitCnt == 1) begin
				waitCnt <= 0;
				chanCnt <= 0;
			end
			// one reading per cycle, back to back
			if (chanCnt < 5) begin
				resultValid <= 1'b1;
				resultChan <= chanCnt[4:0];
				resultValue <= level;
				chanCnt <= chanCnt + 1;
			end
		end
	end
endmodule : scan_engine_model

// [tb/tb_digital_io_totalizer_alarm_unit.sv]
// self-checking bench of the digital i/o, totalizer and alarm unit
`timescale 1ns/1ns
module tb_digital_io_totalizer_alarm_unit;
	import dio_pkg::*;
	localparam int TICKS = 10; // short second keeps intervals brief
	logic ref_clk = 1'b0; // system clock
	logic rstn = 1'b0; // reset, active low
	logic [7:0] regAddr = 8'h00; // bus address
	logic [31:0] regWdata = 32'h0; // bus write data
	logic regWr = 1'b0; // write strobe
	logic regRd = 1'b0; // read strobe
	logic [31:0] regRdata; // bus read data
	logic [7:0] digInPin = 8'hff; // inputs, idle high
	logic totalPin = 1'b1; // totalizer pin, idle high
	logic externalScanPinN = 1'b1; // scan pin, open
	logic [7:0] digOutN; // digital outputs
	logic [3:0] alarmOutN; // alarm outputs
	logic scanStart; // scan request
	logic resultValid; // reading strobe
	logic [4:0] resultChan; // reading channel
	logic signed [31:0] resultValue; // reading value
	logic signed [31:0] level = 32'sd0; // value the model reports
	int n_fail = 0; // mismatches
	int comparisons = 0; // checks made
	int cyc = 0; // cycle counter for the time limit
	int scanCnt = 0; // scan requests seen
	int lastAt = 0; // cycle of the latest request

	digital_io_totalizer_alarm_unit #(.TICK_CYCLES(TICKS)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.digInPin(digInPin), .totalPin(totalPin), .externalScanPinN(externalScanPinN),
		.digOutN(digOutN), .alarmOutN(alarmOutN), .scanStart(scanStart), .resultValid(resultValid),
		.resultChan(resultChan), .resultValue(resultValue));
	scan_engine_model u_scan (.ref_clk(ref_clk), .rstn(rstn), .scanStart(scanStart), .level(level),
		.resultValid(resultValid), .resultChan(resultChan), .resultValue(resultValue));

	// clock generator
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	// scan request log and hang guard
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (scanStart === 1'b1) begin
			scanCnt <= scanCnt + 1;
			lastAt <= cyc;
		end
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		chk(nm, regRdata, exp);
	endtask : rd

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : idle

	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			totalPin <= 1'b0;
			repeat (3) @(posedge ref_clk);
			totalPin <= 1'b1;
			repeat (3) @(posedge ref_clk);
		end
		idle(4);
	endtask : pulse

	task automatic wait_scan();
		int n;
		n = scanCnt;
		for (int i = 0; i < 300 && scanCnt == n; i++) idle(1);
		chk("scan arrival", 32'(scanCnt - n), 32'd1);
	endtask : wait_scan

	task automatic t_reset();
		chk("outputs at rest", 32'(digOutN), 32'hff);
		chk("alarms at rest", 32'(alarmOutN), 32'hf);
		rd("empty address", 8'hfc, 32'h0);
	endtask : t_reset

	task automatic t_inputs();
		rd("word all high", OFF_INPUT_WORD_QUERY, 32'd255);
		for (int n = 0; n < 8; n++) begin
			@(posedge ref_clk);
			digInPin <= ~(8'h01 << n);
			idle(5);
			rd("word grounded", OFF_INPUT_WORD_QUERY, {24'h0, ~(8'h01 << n)});
		end
		digInPin <= 8'hff;
	endtask : t_inputs

	task automatic t_outputs();
		for (int n = 0; n < 8; n++) begin
			wr(OFF_OUT_CMD, 32'(n));
			idle(2);
			chk("output on", 32'(digOutN), 32'({8'hff << (n + 1)}));
		end
		wr(OFF_OUT_CMD, 32'h0000_0108); // number 8 must do nothing
		idle(2);
		chk("bad number", 32'(digOutN), 32'h00);
		for (int n = 0; n < 8; n++) begin
			wr(OFF_OUT_CMD, 32'h100 | 32'(n));
			idle(2);
			chk("output off", 32'(digOutN), 32'(8'hff >> (7 - n)));
		end
	endtask : t_outputs

	task automatic t_total();
		rd("count at start", OFF_TOTAL, 32'h0);
		pulse(1);
		rd("one pulse", OFF_TOTAL, 32'd1);
		pulse(1);
		rd("two pulses", OFF_TOTAL, 32'd2);
		wr(OFF_TOTAL, 32'd65534);
		pulse(1);
		rd("full range", OFF_TOTAL, 32'd65535);
		pulse(1);
		rd("overrun", OFF_TOTAL, 32'h1ffff);
		pulse(1);
		rd("held overrun", OFF_TOTAL, 32'h1ffff);
		// zero request outside totalizer mode must be ignored
		wr(OFF_TOTAL_ZERO, 32'h1);
		rd("zero outside mode", OFF_TOTAL, 32'h1ffff);
		wr(OFF_CTRL, 32'h4);
		wr(OFF_TOTAL_ZERO, 32'h1);
		rd("zeroed", OFF_TOTAL, 32'h0);
		pulse(10);
		rd("periodic input", OFF_TOTAL, 32'd10);
	endtask : t_total

	task automatic t_alarm();
		int t;
		for (int i = 0; i < 4; i++) wr(OFF_LIMIT0 + 8'(i * 4), 32'd1000);
		level <= 32'sd1000;
		wr(OFF_INTERVAL, 32'd2);
		wr(OFF_CTRL, 32'h1);
		wait_scan();
		wait_scan();
		chk("alarms at limit", 32'(alarmOutN), 32'hf);
		t = lastAt;
		wait_scan();
		chk("scan period", 32'(lastAt - t), 32'(2 * TICKS));
		level <= 32'sd1001;
		t = lastAt;
		wait_scan();
		chk("scan period", 32'(lastAt - t), 32'(2 * TICKS));
		idle(10);
		chk("alarms above limit", 32'(alarmOutN), 32'h0);
		// back below the limit, every alarm must return to off
		level <= 32'sd999;
		wait_scan();
		idle(10);
		chk("alarms below limit", 32'(alarmOutN), 32'hf);
		wr(OFF_CTRL, 32'h0);
	endtask : t_alarm

	task automatic t_interval();
		int t;
		wr(OFF_INTERVAL, 32'd2);
		wr(OFF_CTRL, 32'h1);
		wait_scan();
		t = lastAt;
		wait_scan();
		chk("interval gap", 32'(lastAt - t), 32'(2 * TICKS));
		wr(OFF_CTRL, 32'h0);
	endtask : t_interval

	task automatic t_ext();
		int t;
		int n;
		wr(OFF_INTERVAL, 32'd10);
		wr(OFF_CTRL, 32'h1);
		wait_scan();
		idle(30);
		n = scanCnt;
		externalScanPinN <= 1'b0;
		idle(10);
		externalScanPinN <= 1'b1;
		idle(10);
		chk("closure disabled", 32'(scanCnt - n), 32'd0);
		wr(OFF_CTRL, 32'h3);
		wait_scan();
		t = lastAt;
		idle(30);
		n = scanCnt;
		externalScanPinN <= 1'b0;
		idle(10);
		chk("single extra scan", 32'(scanCnt - n), 32'd1);
		externalScanPinN <= 1'b1;
		wait_scan();
		chk("period kept", 32'(lastAt - t), 32'(10 * TICKS));
		wr(OFF_CTRL, 32'h0);
	endtask : t_ext

	// main sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		idle(1);
		t_reset();
		t_inputs();
		t_outputs();
		t_total();
		t_alarm();
		t_interval();
		t_ext();
		wrap_up();
	end
endmodule : tb_digital_io_totalizer_alarm_unit
